// *** src/uepc_pkg.sv ***
// constants, commands and states of the eprom host controller
// assumes a 25 MHz core clock and the eprom wired straight to the pins
// Operation
// - program voltage raised before any pulse
// - address, data stable, then one strobe pulse
// - strobe pulse never exceeds the maximum width
// - strobe never held statically low while programming
// - exactly one pulse per programmed address
// - unpulsed part with voltage stays unprogrammed
// - verify samples after data valid delay
// - idle parts rest in standby, gate released
package uepc_pkg;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 8;
  localparam int TMR_W = 21;
  localparam int CLK_PERIOD_NS = 40;
  // --------------------------------------------------------------------
  // timing in ns as printed, cycles derived
  // --------------------------------------------------------------------
  localparam int PULSE_NOM_NS = 50_000_000;
  localparam int PULSE_MAX_NS = 55_000_000;
  localparam int SETUP_NS = 2_000;
  localparam int HOLD_NS = 2_000;
  localparam int VPP_RECOVER_NS = 2_000;
  localparam int ADDRESS_TO_DATA_DELAY_NS = 450;
  localparam int VERIFY_DATA_VALID_DELAY_NS = 1_000;
  localparam int SYNC_CYCLES = 2;
  localparam int PULSE_NOM_CYCLES = PULSE_NOM_NS / CLK_PERIOD_NS;
  localparam int PULSE_MAX_CYCLES = PULSE_MAX_NS / CLK_PERIOD_NS;
  localparam int SETUP_CYCLES = (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HOLD_CYCLES = (HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RECOVER_CYCLES = (VPP_RECOVER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int READ_CYCLES = (ADDRESS_TO_DATA_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + SYNC_CYCLES;
  localparam int VERIFY_CYCLES = (VERIFY_DATA_VALID_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + SYNC_CYCLES;
  localparam logic [ADDR_W-1:0] ADDR_RST = 12'h000;
  localparam logic [DATA_W-1:0] DATA_RST = 8'hFF;
  // --------------------------------------------------------------------
  // commands and states
  // --------------------------------------------------------------------
  typedef enum logic [1:0] {
    UEPC_OP_READ = 2'h0,
    UEPC_OP_PROGRAM = 2'h1,
    UEPC_OP_VERIFY = 2'h2
  } uepc_op_t;
  typedef enum logic [7:0] {
    ST_IDLE = 8'h01,
    ST_RD_WAIT = 8'h02,
    ST_PG_VPP = 8'h04,
    ST_PG_PULSE = 8'h08,
    ST_PG_HOLD = 8'h10,
    ST_VF_WAIT = 8'h20,
    ST_RECOVER = 8'h40,
    ST_SPARE = 8'h80
  } uepc_state_t;
endpackage

// *** src/uepc_timer_if.sv ***
// load and expiry signals between the controller and its phase timer
// assumes both ends run on the core clock
interface uepc_timer_if;
  logic load;
  logic [uepc_pkg::TMR_W-1:0] value;
  logic expired;
  modport ctrl (output load, output value, input expired);
  modport timer (input load, input value, output expired);
endinterface

// *** src/uepc_timer.sv ***
// down counter timing each phase of an eprom access
// assumes load is a one-cycle request from the controller
module uepc_timer (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic clk_en_in,
  uepc_timer_if.timer tmr
);
  logic [uepc_pkg::TMR_W-1:0] count_q;
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      count_q <= '0;
    end else if (clk_en_in) begin
      if (tmr.load) begin
        count_q <= tmr.value;
      end else if (count_q != '0) begin
        count_q <= count_q - 1'b1;
      end
    end
  end
  assign tmr.expired = (count_q == '0);
endmodule

// *** src/uepc_ctrl.sv ***
// host controller reading, programming and verifying a 4096 x 8 eprom
// assumes data pins resolved outside from data_oe_out; vpp_on_out switches the
// high programming voltage onto the output-gate pin
module uepc_ctrl #(
  parameter int PULSE_CYCLES = uepc_pkg::PULSE_NOM_CYCLES,
  parameter int PULSE_MAX = uepc_pkg::PULSE_MAX_CYCLES
) (
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  input wire logic clk_en_in,
  input wire logic cmd_valid_in,
  input wire logic [1:0] cmd_op_in,
  input wire logic [uepc_pkg::ADDR_W-1:0] cmd_addr_in,
  input wire logic [uepc_pkg::DATA_W-1:0] cmd_data_in,
  output logic busy_out,
  output logic done_out,
  output logic [uepc_pkg::DATA_W-1:0] rdata_out,
  output logic verify_ok_out,
  output logic [uepc_pkg::ADDR_W-1:0] addr_out,
  output logic chip_select_program_strobe_n_out,
  output logic output_gate_n_out,
  output logic vpp_on_out,
  input wire logic [uepc_pkg::DATA_W-1:0] data_in,
  output logic [uepc_pkg::DATA_W-1:0] data_out,
  output logic data_oe_out
);
  logic rst_s1_q, rst_q;
  logic [uepc_pkg::DATA_W-1:0] data_s1_q, data_s2_q;
  uepc_pkg::uepc_state_t state_q, state_d;
  logic [1:0] op_q;
  logic [uepc_pkg::ADDR_W-1:0] addr_q;
  logic [uepc_pkg::DATA_W-1:0] wdata_q;
  logic [uepc_pkg::DATA_W-1:0] rdata_q;
  logic ok_q, busy_q, done_q, strobe_n_q, gate_n_q, vpp_q, data_oe_q;
  logic accept;
  uepc_timer_if tmr_if ();

  // --------------------------------------------------------------------
  // reset release and pin synchroniser
  // --------------------------------------------------------------------
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rst_s1_q <= 1'b0;
      rst_q <= 1'b0;
    end else if (clk_en_in) begin
      rst_s1_q <= 1'b1;
      rst_q <= rst_s1_q;
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_q) begin
    if (!rst_q) begin
      data_s1_q <= uepc_pkg::DATA_RST;
      data_s2_q <= uepc_pkg::DATA_RST;
    end else if (clk_en_in) begin
      data_s1_q <= data_in;
      data_s2_q <= data_s1_q;
    end
  end

  uepc_timer u_timer (
    .clk_in(core_clk_in),
    .rst_n_in(rst_q),
    .clk_en_in(clk_en_in),
    .tmr(tmr_if.timer)
  );

  // --------------------------------------------------------------------
  // sequencing
  // --------------------------------------------------------------------
  assign accept = cmd_valid_in && (state_q == uepc_pkg::ST_IDLE) && (cmd_op_in != 2'h3);

  always_comb begin
    state_d = state_q;
    case (state_q)
      uepc_pkg::ST_IDLE: begin
        if (accept) begin
          case (cmd_op_in)
            uepc_pkg::UEPC_OP_READ: state_d = uepc_pkg::ST_RD_WAIT;
            uepc_pkg::UEPC_OP_PROGRAM: state_d = uepc_pkg::ST_PG_VPP;
            default: state_d = uepc_pkg::ST_VF_WAIT;
          endcase
        end
      end
      uepc_pkg::ST_RD_WAIT: if (tmr_if.expired) state_d = uepc_pkg::ST_IDLE;
      uepc_pkg::ST_PG_VPP: if (tmr_if.expired) state_d = uepc_pkg::ST_PG_PULSE;
      uepc_pkg::ST_PG_PULSE: if (tmr_if.expired) state_d = uepc_pkg::ST_PG_HOLD;
      uepc_pkg::ST_PG_HOLD: if (tmr_if.expired) state_d = uepc_pkg::ST_RECOVER;
      uepc_pkg::ST_VF_WAIT: if (tmr_if.expired) state_d = uepc_pkg::ST_IDLE;
      uepc_pkg::ST_RECOVER: if (tmr_if.expired) state_d = uepc_pkg::ST_IDLE;
      default: state_d = uepc_pkg::ST_IDLE;
    endcase
  end

  always_comb begin
    tmr_if.load = (state_d != state_q);
    case (state_d)
      uepc_pkg::ST_RD_WAIT: tmr_if.value = uepc_pkg::TMR_W'(uepc_pkg::READ_CYCLES - 1);
      uepc_pkg::ST_PG_VPP: tmr_if.value = uepc_pkg::TMR_W'(uepc_pkg::SETUP_CYCLES - 1);
      uepc_pkg::ST_PG_PULSE: tmr_if.value = uepc_pkg::TMR_W'(PULSE_CYCLES - 1);
      uepc_pkg::ST_PG_HOLD: tmr_if.value = uepc_pkg::TMR_W'(uepc_pkg::HOLD_CYCLES - 1);
      uepc_pkg::ST_VF_WAIT: tmr_if.value = uepc_pkg::TMR_W'(uepc_pkg::VERIFY_CYCLES - 1);
      uepc_pkg::ST_RECOVER: tmr_if.value = uepc_pkg::TMR_W'(uepc_pkg::RECOVER_CYCLES - 1);
      default: tmr_if.value = '0;
    endcase
  end

  always_ff @(posedge core_clk_in or negedge rst_q) begin
    if (!rst_q) begin
      state_q <= uepc_pkg::ST_IDLE;
    end else if (clk_en_in) begin
      state_q <= state_d;
    end
  end

  // --------------------------------------------------------------------
  // command capture and results
  // --------------------------------------------------------------------
  always_ff @(posedge core_clk_in or negedge rst_q) begin
    if (!rst_q) begin
      op_q <= 2'h0;
      addr_q <= uepc_pkg::ADDR_RST;
      wdata_q <= uepc_pkg::DATA_RST;
    end else if (clk_en_in && accept) begin
      op_q <= cmd_op_in;
      addr_q <= cmd_addr_in;
      wdata_q <= cmd_data_in;
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_q) begin
    if (!rst_q) begin
      rdata_q <= uepc_pkg::DATA_RST;
      ok_q <= 1'b0;
      done_q <= 1'b0;
      busy_q <= 1'b0;
    end else if (clk_en_in) begin
      busy_q <= (state_d != uepc_pkg::ST_IDLE);
      done_q <= (state_q != uepc_pkg::ST_IDLE) && (state_d == uepc_pkg::ST_IDLE);
      if ((state_q == uepc_pkg::ST_RD_WAIT || state_q == uepc_pkg::ST_VF_WAIT) && tmr_if.expired) begin
        rdata_q <= data_s2_q;
        ok_q <= (data_s2_q == wdata_q);
      end
    end
  end

  // --------------------------------------------------------------------
  // pin drive
  // --------------------------------------------------------------------
  always_ff @(posedge core_clk_in or negedge rst_q) begin
    if (!rst_q) begin
      strobe_n_q <= 1'b1;
      gate_n_q <= 1'b1;
      vpp_q <= 1'b0;
      data_oe_q <= 1'b0;
    end else if (clk_en_in) begin
      // strobe low only in pulse or access phases, standby otherwise
      strobe_n_q <= !(state_d == uepc_pkg::ST_PG_PULSE || state_d == uepc_pkg::ST_RD_WAIT
                      || state_d == uepc_pkg::ST_VF_WAIT);
      gate_n_q <= !(state_d == uepc_pkg::ST_RD_WAIT || state_d == uepc_pkg::ST_VF_WAIT);
      vpp_q <= (state_d == uepc_pkg::ST_PG_VPP || state_d == uepc_pkg::ST_PG_PULSE
                || state_d == uepc_pkg::ST_PG_HOLD);
      data_oe_q <= (state_d == uepc_pkg::ST_PG_VPP || state_d == uepc_pkg::ST_PG_PULSE
                    || state_d == uepc_pkg::ST_PG_HOLD);
    end
  end

  assign busy_out = busy_q;
  assign done_out = done_q;
  assign rdata_out = rdata_q;
  assign verify_ok_out = ok_q;
  assign addr_out = addr_q;
  assign chip_select_program_strobe_n_out = strobe_n_q;
  assign output_gate_n_out = gate_n_q;
  assign vpp_on_out = vpp_q;
  assign data_out = wdata_q;
  assign data_oe_out = data_oe_q;

  // --------------------------------------------------------------------
  // checks
  // --------------------------------------------------------------------
  int unsigned low_len_q;
  logic [1:0] pulses_q;
  always_ff @(posedge core_clk_in or negedge rst_q) begin
    if (!rst_q) begin
      low_len_q <= 0;
      pulses_q <= 2'h0;
    end else if (clk_en_in) begin
      low_len_q <= strobe_n_q ? 0 : low_len_q + 1;
      if (accept) begin
        pulses_q <= 2'h0;
      end else if (!strobe_n_q && vpp_q && low_len_q == 0 && pulses_q != 2'h3) begin
        pulses_q <= pulses_q + 2'h1;
      end
    end
  end

  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rst_q);

  chk_vpp_before_pulse: assert property ($fell(strobe_n_q) && vpp_q |-> $past(vpp_q, 2) && data_oe_q)
    else $error("strobe fell without program voltage settled");
  chk_pulse_stable: assert property (vpp_q && !strobe_n_q |-> $stable(addr_q) && $stable(wdata_q))
    else $error("address or data moved during program pulse");
  chk_pulse_bound: assert property ($rose(strobe_n_q) && $past(vpp_q) |-> low_len_q == PULSE_CYCLES
                                    && low_len_q <= PULSE_MAX)
    else $error("program pulse width wrong");
  chk_no_static_low: assert property (vpp_q && !strobe_n_q |-> state_q == uepc_pkg::ST_PG_PULSE
                                      && low_len_q < PULSE_CYCLES)
    else $error("strobe held low while programming");
  chk_one_pulse: assert property ($rose(done_q) && op_q == uepc_pkg::UEPC_OP_PROGRAM |-> pulses_q == 2'h1)
    else $error("program command did not give exactly one pulse");
  chk_inhibit_high: assert property (vpp_q && state_q != uepc_pkg::ST_PG_PULSE |-> strobe_n_q)
    else $error("strobe low outside pulse while voltage on");
  chk_verify_wait: assert property ($rose(done_q) && op_q == uepc_pkg::UEPC_OP_VERIFY
                                    |-> $past(low_len_q) >= uepc_pkg::VERIFY_CYCLES - 1 && !vpp_q)
    else $error("verify sampled too early");
  chk_standby_idle: assert property (state_q == uepc_pkg::ST_IDLE |-> strobe_n_q && gate_n_q && !vpp_q)
    else $error("idle part not in standby");
  cov_read: cover property ($rose(done_q) && op_q == uepc_pkg::UEPC_OP_READ);
  cov_program: cover property ($rose(done_q) && op_q == uepc_pkg::UEPC_OP_PROGRAM);
  cov_verify_ok: cover property ($rose(done_q) && op_q == uepc_pkg::UEPC_OP_VERIFY && ok_q);
endmodule

// *** test/uepc_eprom_model.sv ***
// partner: 4096 x 8 uv eprom with read, standby and program
// assumes pins wired straight to the controller; no clock of its own
module uepc_eprom_model #(
  parameter int ACC_NS = 450,
  parameter int PW_MAX_NS = 880
) (
  input wire logic [11:0] addr_in,
  input wire logic sel_n_in,
  input wire logic gate_n_in,
  input wire logic vpp_in,
  input wire logic [7:0] data_in,
  output logic [7:0] data_out,
  output logic drive_out,
  output int faults_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [4096];
  logic [7:0] last = 8'hFF;
  logic en;
  logic en_d;
  realtime t_fall;
  initial begin
    foreach (mem[i]) mem[i] = 8'hFF;
    faults_out = 0;
  end
  assign en = !sel_n_in && !gate_n_in && !vpp_in;
  assign #(ACC_NS) en_d = en;
  assign drive_out = en && en_d;
  always @(negedge sel_n_in) t_fall = $realtime;
  always @(posedge sel_n_in) if (vpp_in) begin
    if ($realtime - t_fall > PW_MAX_NS) faults_out++;
    mem[addr_in] = mem[addr_in] & data_in;
  end
  // released pins show the inverse of the last byte
  always @* if (drive_out) last = mem[addr_in];
  assign data_out = drive_out ? mem[addr_in] : ~last;
endmodule

// *** test/uepc_ctrl_tb.sv ***
// testbench of the eprom host controller against the eprom model
// assumes short sim pulse of 20 cycles, max 22; inputs driven on falling edge
module uepc_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, rst_n = 0, valid = 0, clk_en = 1;
  logic [1:0] op = 2'h0;
  logic [11:0] addr = 12'h000;
  logic [7:0] wdata = 8'h00;
  logic busy, done, ok, sel_n, gate_n, vpp, oe, drive;
  logic [7:0] rdata, dout, mdata, pins;
  logic [11:0] pin_addr;
  int n_fail = 0, checks_done = 0, cyc = 0, plen = 0, pmax = 0, npulse = 0, nbad = 0, mfault;
  initial forever #20 clk = ~clk;
  assign pins = oe ? dout : mdata;
  uepc_ctrl #(.PULSE_CYCLES(20), .PULSE_MAX(22)) uepc_ctrl_i (.core_clk_in(clk), .rst_n_in(rst_n),
    .clk_en_in(clk_en), .cmd_valid_in(valid), .cmd_op_in(op), .cmd_addr_in(addr), .cmd_data_in(wdata),
    .busy_out(busy), .done_out(done), .rdata_out(rdata), .verify_ok_out(ok), .addr_out(pin_addr),
    .chip_select_program_strobe_n_out(sel_n), .output_gate_n_out(gate_n), .vpp_on_out(vpp),
    .data_in(pins), .data_out(dout), .data_oe_out(oe));
  uepc_eprom_model #(.ACC_NS(450), .PW_MAX_NS(880)) uepc_eprom_model_i (.addr_in(pin_addr),
    .sel_n_in(sel_n), .gate_n_in(gate_n), .vpp_in(vpp), .data_in(pins), .data_out(mdata),
    .drive_out(drive), .faults_out(mfault));
  // ----------------------------------------
  // pin monitor and timeout
  // ----------------------------------------
  always @(negedge clk) begin
    if (!sel_n && oe) plen++;
    if (!sel_n && oe && plen == 1) npulse++;
    if (sel_n) plen = 0;
    if (plen > pmax) pmax = plen;
    if ((!sel_n && oe && !vpp) || (!gate_n && (oe || sel_n)) || (oe && drive)) nbad++;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      n_fail++;
      print_verdict();
    end
  end
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task automatic cmd(input logic [1:0] o, input logic [11:0] a, input logic [7:0] d, output int lat);
    @(negedge clk);
    valid = 1;
    op = o;
    addr = a;
    wdata = d;
    @(negedge clk);
    valid = 0;
    lat = 0;
    while (done !== 1'b1 && lat < 400) begin
      @(negedge clk);
      lat++;
    end
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic sc_reset;
    check("sel_n", sel_n, 1'b1);
    check("gate_n", gate_n, 1'b1);
    check("vpp", vpp, 1'b0);
    check("data_oe", oe, 1'b0);
    check("rdata", rdata, 8'hFF);
  endtask
  task automatic sc_read_erased;
    int lat;
    cmd(2'h0, 12'hFFF, 8'h00, lat);
    check("read latency", lat, uepc_pkg::READ_CYCLES);
    check("erased byte", rdata, 8'hFF);
    check("address pins", pin_addr, 12'hFFF);
    check("released sel", sel_n, 1'b1);
  endtask
  task automatic sc_program;
    int lat;
    int exp_lat;
    exp_lat = uepc_pkg::SETUP_CYCLES + 20 + uepc_pkg::HOLD_CYCLES + uepc_pkg::RECOVER_CYCLES;
    pmax = 0;
    npulse = 0;
    cmd(2'h1, 12'h123, 8'hA5, lat);
    check("program latency", lat, exp_lat);
    check("pulse width", pmax, 20);
    check("pulse count", npulse, 1);
    cmd(2'h0, 12'h123, 8'h00, lat);
    check("programmed byte", rdata, 8'hA5);
    cmd(2'h0, 12'h124, 8'h00, lat);
    check("neighbour byte", rdata, 8'hFF);
  endtask
  task automatic sc_verify;
    int lat;
    cmd(2'h2, 12'h123, 8'hA5, lat);
    check("verify latency", lat, uepc_pkg::VERIFY_CYCLES);
    check("verify ok", ok, 1'b1);
    cmd(2'h2, 12'h123, 8'hA4, lat);
    check("verify mismatch", ok, 1'b0);
  endtask
  task automatic sc_freeze;
    int lat;
    @(negedge clk);
    valid = 1;
    op = 2'h0;
    addr = 12'h123;
    @(negedge clk);
    valid = 0;
    clk_en = 0;
    repeat (30) @(negedge clk);
    check("frozen busy", busy, 1'b1);
    check("frozen sel", sel_n, 1'b0);
    check("frozen done", done, 1'b0);
    clk_en = 1;
    lat = 30;
    while (done !== 1'b1 && lat < 400) begin
      @(negedge clk);
      lat++;
    end
    check("frozen latency", lat, uepc_pkg::READ_CYCLES + 30);
    check("frozen byte", rdata, 8'hA5);
  endtask
  task automatic sc_refuse;
    npulse = 0;
    @(negedge clk);
    valid = 1;
    op = 2'h3;
    repeat (3) @(negedge clk);
    check("op3 busy", busy, 1'b0);
    op = 2'h0;
    @(negedge clk);
    op = 2'h1;
    check("read gate", gate_n, 1'b0);
    repeat (3) @(negedge clk);
    valid = 0;
    repeat (40) @(negedge clk);
    check("refused pulses", npulse, 0);
  endtask
  initial begin
    repeat (20) @(negedge clk);
    rst_n = 1;
    repeat (3) @(negedge clk);
    sc_reset();
    sc_read_erased();
    sc_program();
    sc_verify();
    sc_freeze();
    sc_refuse();
    check("pin faults", nbad, 0);
    check("model faults", mfault, 0);
    print_verdict();
  end
endmodule
